// ===== pkg/asc_if.sv
// Purpose: task-file style link between host end and device end
// Assumes: both ends on CORE_CLK, host writes all registers with one strobe
// Notes: intrq is a level cleared by the next command strobe that starts a busy job
`timescale 1ns/1ps
`default_nettype none
interface asc_if;
	logic cmd_wr;
	logic [7:0] cmd;
	logic [7:0] feature;
	logic [7:0] sect_cnt;
	logic [7:0] lba_low;
	logic [7:0] lba_high;
	logic data_rd;
	logic bsy;
	logic drdy;
	logic drq;
	logic err;
	logic intrq;
	logic [7:0] error;
	logic [7:0] lba_low_out;
	logic [7:0] lba_high_out;
	logic [15:0] data;
	logic data_valid;
	modport dev (input cmd_wr, cmd, feature, sect_cnt, lba_low, lba_high, data_rd,
		output bsy, drdy, drq, err, intrq, error, lba_low_out, lba_high_out, data, data_valid);
	modport host (output cmd_wr, cmd, feature, sect_cnt, lba_low, lba_high, data_rd,
		input bsy, drdy, drq, err, intrq, error, lba_low_out, lba_high_out, data, data_valid);
endinterface
`default_nettype wire

// ===== pkg/asc_pkg.sv
// Purpose: shared constants for the command engine and its host end
// Assumes: 40 MHz core clock
// Notes: durations of internal jobs are small stand-ins for media work
package asc_pkg;
	// ========================================
	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int AUTOSAVE_MIN = 15;
	localparam int AUTOSAVE_TICKS = AUTOSAVE_MIN * 60 * 1000 / TICK_MS;
	localparam logic [15:0] SAVE_CYCLES = 16'h0008;
	localparam logic [15:0] FETCH_CYCLES = 16'h0004;
	localparam logic [15:0] TEST_CYCLES = 16'h0040;
	localparam logic [15:0] ERASE_CYCLES = 16'h0020;
	localparam logic [15:0] OFFLINE_CYCLES = 16'h0100;
	localparam logic [7:0] XFER_LAST = 8'hff; // 256 words = 512 bytes
	// ========================================
	// opcodes
	localparam logic [7:0] OP_SMART = 8'hb0;
	localparam logic [7:0] OP_SET_PW = 8'hf1;
	localparam logic [7:0] OP_UNLOCK = 8'hf2;
	localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
	localparam logic [7:0] OP_DIS_PW = 8'hf6;
	localparam logic [7:0] OP_STANDBY_IMM = 8'he0;
	localparam logic [7:0] OP_STANDBY = 8'he2;
	localparam logic [7:0] OP_SLEEP = 8'he6;
	// ========================================
	// smart subcommands and arguments
	localparam logic [7:0] SM_READ_DATA = 8'hd0;
	localparam logic [7:0] SM_READ_THR = 8'hd1;
	localparam logic [7:0] SM_AUTOSAVE = 8'hd2;
	localparam logic [7:0] SM_SAVE = 8'hd3;
	localparam logic [7:0] SM_EXEC = 8'hd4;
	localparam logic [7:0] SM_HOLE = 8'hd7;
	localparam logic [7:0] SM_LAST = 8'hdb;
	localparam logic [7:0] AS_OFF = 8'h00;
	localparam logic [7:0] AS_ON = 8'hf1;
	localparam logic [7:0] EX_COLLECT = 8'h00;
	localparam logic [7:0] EX_SHORT = 8'h01;
	localparam logic [7:0] EX_EXTEND = 8'h02;
	localparam logic [7:0] EX_SELECT = 8'h04;
	localparam logic [7:0] EX_ABORT = 8'h7f;
	localparam logic [7:0] EX_CAP_SHORT = 8'h81;
	localparam logic [7:0] EX_CAP_EXTEND = 8'h82;
	localparam logic [7:0] EX_CAP_SELECT = 8'h84;
	// ========================================
	// answers and reset values
	localparam logic [7:0] ERR_ABRT = 8'h04;
	localparam logic [7:0] FAIL_LBA_LOW = 8'hf4;
	localparam logic [7:0] FAIL_LBA_HIGH = 8'h2c;
	localparam logic [15:0] MASTER_PW_RST = 16'h2020;
	localparam logic [7:0] STS_PASS = 8'h00;
	localparam logic [7:0] STS_ABORTED = 8'h10;
	localparam logic [7:0] STS_FAILED = 8'h70;
	localparam logic [7:0] STS_RUNNING = 8'hf0;
	localparam logic [7:0] THR_PATTERN = 8'h5a;
endpackage

// ===== sim/asc_link_monitor.sv
// Purpose: link checker for the command engine
// Assumes: one clock domain, reset RESET_N
// Notes: sees only the shared link signals
`timescale 1ns/1ps
`default_nettype none
module asc_link_monitor (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd,
	input wire logic [7:0] feature,
	input wire logic [7:0] sect_cnt,
	input wire logic [7:0] lba_low,
	input wire logic data_rd,
	input wire logic bsy,
	input wire logic drdy,
	input wire logic drq,
	input wire logic err,
	input wire logic intrq,
	input wire logic [7:0] error,
	input wire logic [7:0] lba_low_out,
	input wire logic [7:0] lba_high_out,
	input wire logic data_valid
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	// ========================================
	// taken commands
	logic take;
	logic sm;
	assign take = cmd_wr && !bsy && !drq;
	assign sm = take && cmd == asc_pkg::OP_SMART;
	chk_drdy_held: assert property (drdy) else $error("drdy dropped");
	chk_unsup_abort: assert property (take && cmd inside {8'h3d, 8'h92, 8'hb4}
		|=> err && intrq && error == asc_pkg::ERR_ABRT) else $error("unsupported opcode not aborted");
	chk_bad_feature: assert property (sm && (feature < 8'hd0 || feature > 8'hdb || feature == 8'hd7)
		|=> err && error == asc_pkg::ERR_ABRT) else $error("bad subcommand not aborted");
	chk_autosave_bad: assert property (sm && feature == 8'hd2 && !(sect_cnt inside {8'h00, 8'hf1})
		|-> ##[1:3] err && intrq) else $error("bad autosave count not refused");
	chk_save_busy: assert property (sm && feature == 8'hd3
		|=> bsy ##[1:10] !bsy && intrq) else $error("save sequence wrong");
	chk_read_drq: assert property (sm && feature == 8'hd0
		|=> bsy ##[1:10] drq && intrq && !bsy) else $error("read data handshake wrong");
	chk_word_answer: assert property (data_rd |=> data_valid) else $error("word not delivered");
	chk_offline_done: assert property (sm && feature == 8'hd4 && lba_low == 8'h00
		|=> !bsy && intrq && !err) else $error("offline start not completed first");
	chk_captive_busy: assert property (sm && feature == 8'hd4 && lba_low == 8'h81
		|=> bsy[*8] ##[1:70] !bsy && intrq) else $error("captive test not busy");
	chk_fail_regs: assert property (intrq && err && lba_low_out == 8'hf4
		|-> lba_high_out == 8'h2c && error == asc_pkg::ERR_ABRT) else $error("fail registers wrong");
	cov_read: cover property (sm && feature == 8'hd0 ##[1:10] drq);
	cov_fail: cover property (intrq && err && lba_low_out == 8'hf4);
	cov_offline: cover property (sm && feature == 8'hd4 && lba_low == 8'h00);
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: end-to-end bench, host end facing device end
// Assumes: 40 MHz clock, shortened autosave timer
// Notes: commands go in through the host user side
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [7:0] SM = asc_pkg::OP_SMART;
	localparam logic [7:0] Z = 8'h00;
	logic CORE_CLK, RESET_N, REQ, POWER_UP, POWER_DOWN, IDLE_ENTER, TEST_FAIL, thr;
	logic [7:0] REQ_CMD, REQ_FEAT, REQ_CNT, REQ_LBA_LOW, REQ_LBA_HIGH;
	logic READY, DONE, DONE_ERR, RD_VALID, CMD_STROBE, ATTR_SAVE, LOCKED, AUTOSAVE_ON, OFFLINE_RUN;
	logic [7:0] DONE_ERROR, DONE_LBA_LOW, DONE_LBA_HIGH, CMD_CODE, SELFTEST_STATUS;
	logic [15:0] RD_DATA;
	logic [7:0] unsup [3] = '{8'h3d, 8'h92, 8'hb4};
	logic [7:0] offl [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
	logic [7:0] capt [3] = '{8'h81, 8'h82, 8'h84};
	int failures = 0, n_compared = 0, saves = 0, words = 0, cycles = 0, bad = 0, strobes = 0, s0;
	asc_if link();
	asc_device #(.TICK_CYCLES(4), .AUTOSAVE_TICKS(10)) u_asc_device (.CORE_CLK, .RESET_N, .LINK(link),
		.POWER_UP, .POWER_DOWN, .IDLE_ENTER, .TEST_FAIL, .CMD_STROBE, .CMD_CODE, .ATTR_SAVE,
		.LOCKED, .AUTOSAVE_ON, .OFFLINE_RUN, .SELFTEST_STATUS);
	asc_host u_asc_host (.CORE_CLK, .RESET_N, .LINK(link), .REQ, .REQ_CMD, .REQ_FEAT, .REQ_CNT,
		.REQ_LBA_LOW, .REQ_LBA_HIGH, .READY, .DONE, .DONE_ERR, .DONE_ERROR, .DONE_LBA_LOW,
		.DONE_LBA_HIGH, .RD_DATA, .RD_VALID);
	asc_link_monitor u_asc_link_monitor (.CORE_CLK, .RESET_N, .cmd_wr(link.cmd_wr), .cmd(link.cmd),
		.feature(link.feature), .sect_cnt(link.sect_cnt), .lba_low(link.lba_low), .data_rd(link.data_rd),
		.bsy(link.bsy), .drdy(link.drdy), .drq(link.drq), .err(link.err), .intrq(link.intrq),
		.error(link.error), .lba_low_out(link.lba_low_out), .lba_high_out(link.lba_high_out),
		.data_valid(link.data_valid));
	initial begin
		CORE_CLK = 0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	// ========================================
	// observers and hang guard
	always @(posedge CORE_CLK) begin
		cycles++;
		if (ATTR_SAVE === 1'b1) saves++;
		if (CMD_STROBE === 1'b1) strobes++;
		if (RD_VALID === 1'b1) begin
			// attribute byte is the running save count
			if (RD_DATA !== {words[7:0], thr ? words[7:0] ^ asc_pkg::THR_PATTERN : saves[7:0]}) bad++;
			words++;
		end
		if (cycles == 60000) begin
			failures++;
			conclude();
		end
	end
	// ========================================
	// tasks
	task tick(input int n);
		repeat (n) @(posedge CORE_CLK);
		#1;
	endtask
	task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task issue(input logic [7:0] c, f, n, lo, hi);
		int k;
		k = 0;
		while (READY !== 1'b1 && k < 100) begin
			tick(1);
			k++;
		end
		REQ = 1;
		{REQ_CMD, REQ_FEAT, REQ_CNT, REQ_LBA_LOW, REQ_LBA_HIGH} = {c, f, n, lo, hi};
		tick(1);
		REQ = 0;
		k = 0;
		// reads take about 800 cycles, so the wait is generous
		while (DONE !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		if (k == 3000) failures++;
	endtask
	task pulse(input int w);
		case (w)
			0: POWER_UP = 1;
			1: POWER_DOWN = 1;
			default: IDLE_ENTER = 1;
		endcase
		tick(1);
		{POWER_UP, POWER_DOWN, IDLE_ENTER} = 3'h0;
		tick(3);
	endtask
	task conclude();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ========================================
	// main sequence
	initial begin
		{RESET_N, REQ, POWER_UP, POWER_DOWN, IDLE_ENTER, TEST_FAIL, thr} = 7'h0;
		{REQ_CMD, REQ_FEAT, REQ_CNT, REQ_LBA_LOW, REQ_LBA_HIGH} = 40'h0;
		tick(3);
		RESET_N = 1;
		tick(2);
		chk("locked at reset", LOCKED, 1'b0);
		foreach (unsup[i]) begin
			issue(unsup[i], Z, Z, Z, Z);
			chk("unsup err", DONE_ERR, 1'b1);
			chk("unsup code", DONE_ERROR, asc_pkg::ERR_ABRT);
		end
		issue(8'h27, Z, Z, Z, Z);
		chk("27h err", DONE_ERR, 1'b0);
		chk("27h code", CMD_CODE, 8'h27);
		chk("27h strobe", 16'(strobes), 16'h1);
		issue(SM, 8'hd2, 8'hf1, Z, Z);
		chk("autosave on", AUTOSAVE_ON, 1'b1);
		issue(SM, 8'hd2, 8'h05, Z, Z);
		chk("autosave bad err", DONE_ERR, 1'b1);
		chk("autosave kept", AUTOSAVE_ON, 1'b1);
		pulse(1);
		pulse(0);
		chk("autosave over power", AUTOSAVE_ON, 1'b1);
		s0 = saves;
		pulse(2);
		chk("idle save", 16'(saves - s0), 16'h1);
		tick(45);
		chk("timer save", 16'(saves - s0 >= 2), 16'h1);
		issue(SM, 8'hd2, Z, Z, Z);
		chk("autosave off", AUTOSAVE_ON, 1'b0);
		s0 = saves;
		pulse(1);
		pulse(0);
		chk("power saves", 16'(saves - s0), 16'h2);
		issue(SM, 8'hd3, Z, Z, Z);
		chk("save cmd", 16'(saves - s0), 16'h3);
		words = 0;
		issue(SM, 8'hd0, Z, Z, Z);
		// last word is counted one edge after DONE
		tick(1);
		chk("attr words", 16'(words), 16'h100);
		chk("attr saved", 16'(saves - s0), 16'h4);
		chk("attr data", 16'(bad), 16'h0);
		words = 0;
		thr = 1;
		issue(SM, 8'hd1, Z, Z, Z);
		tick(1);
		thr = 0;
		chk("thr words", 16'(words), 16'h100);
		chk("thr pattern", 16'(bad), 16'h0);
		foreach (offl[i]) begin
			issue(SM, 8'hd4, Z, offl[i], Z);
			chk("offline err", DONE_ERR, 1'b0);
			chk("offline run", OFFLINE_RUN, 1'b1);
			issue(SM, 8'hd4, Z, 8'h7f, Z);
			chk("abort run", OFFLINE_RUN, 1'b0);
			chk("abort status", SELFTEST_STATUS, asc_pkg::STS_ABORTED);
		end
		foreach (capt[i]) begin
			TEST_FAIL = (i == 1);
			issue(SM, 8'hd4, Z, capt[i], Z);
			chk("captive err", DONE_ERR, TEST_FAIL);
			chk("captive status", SELFTEST_STATUS, TEST_FAIL ? 8'h70 : 8'h00);
			if (TEST_FAIL) begin
				chk("fail error", DONE_ERROR, 8'h04);
				chk("fail lba", {DONE_LBA_HIGH, DONE_LBA_LOW}, 16'h2cf4);
			end
		end
		TEST_FAIL = 0;
		issue(SM, 8'hd4, Z, 8'h03, Z);
		chk("reserved routine", DONE_ERR, 1'b1);
		issue(SM, 8'hd7, Z, Z, Z);
		chk("hole subcommand", DONE_ERR, 1'b1);
		issue(SM, 8'hd4, Z, 8'h00, Z);
		issue(8'h27, Z, Z, Z, Z);
		tick(2);
		chk("resumed", OFFLINE_RUN, 1'b1);
		issue(8'he0, Z, Z, Z, Z);
		tick(2);
		chk("stays stopped", OFFLINE_RUN, 1'b0);
		issue(8'hf1, Z, Z, 8'h78, 8'h56);
		pulse(0);
		chk("user pw locks", LOCKED, 1'b1);
		issue(8'h20, Z, Z, Z, Z);
		chk("media refused", DONE_ERR, 1'b1);
		issue(8'hf2, 8'h01, Z, 8'h20, 8'h20);
		chk("master unlock", LOCKED, 1'b0);
		issue(8'hf1, 8'h01, Z, 8'h34, 8'h12);
		chk("master set", LOCKED, 1'b0);
		issue(8'hf1, Z, 8'h01, 8'h78, 8'h56);
		pulse(0);
		issue(8'hf2, 8'h01, Z, 8'h34, 8'h12);
		chk("max level unlock", LOCKED, 1'b1);
		issue(8'hf4, 8'h01, Z, 8'h34, 8'h12);
		chk("erase unlocks", LOCKED, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire

// ===== verilog/asc_device.sv
// Purpose: command interpreter with security lock and smart subcommands
// Assumes: host strobes a command only while bsy and drq are low
// Notes: RESET_N is factory state; POWER_UP/POWER_DOWN model power cycles
// Overview of operation
// - decode opcode, dispatch to its handler
// - flagged opcodes answer as unsupported
// - factory master password all 20h, unlocked
// - setting master password never enables lock
// - user password set means locked after power-on
// - locked drive rejects media access until unlock
// - high level: master password also unlocks
// - max level: master only via erase unit
// - host loads feature with subcommand first
// - read data: busy, save, drq, interrupt
// - read thresholds: fetch, then 512 bytes out
// - autosave count 00h off, F1h on
// - other nonzero count: unchanged, smart error
// - autosave at first idle, every 15 minutes
// - autosave setting kept; power edges always save
// - save attributes always, busy then interrupt
// - lba low selects offline, captive or abort
// - offline: complete first, run with busy clear
// - new command suspends offline routine promptly
// - resume or stop depending on interrupter
// - captive: busy, test, record, then complete
// - captive fail: err, abrt, F4h, 2Ch
`timescale 1ns/1ps
`default_nettype none
module asc_device #(
	parameter int TICK_CYCLES = asc_pkg::TICK_CYCLES,
	parameter int AUTOSAVE_TICKS = asc_pkg::AUTOSAVE_TICKS
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	asc_if.dev LINK,
	input wire logic POWER_UP,
	input wire logic POWER_DOWN,
	input wire logic IDLE_ENTER,
	input wire logic TEST_FAIL,
	output logic CMD_STROBE,
	output logic [7:0] CMD_CODE,
	output logic ATTR_SAVE,
	output logic LOCKED,
	output logic AUTOSAVE_ON,
	output logic OFFLINE_RUN,
	output logic [7:0] SELFTEST_STATUS
);
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_BUSY = 2'b01, S_XFER = 2'b11} asc_state_e;
	typedef enum logic [2:0] {J_NONE, J_BRIEF, J_ATTR, J_THR, J_SAVE, J_TEST, J_ERASE} asc_job_e;

	// ========================================
	// opcode classes
	function automatic logic is_unsup(input logic [7:0] op);
		case (op)
			8'h3d, 8'h45, 8'h47, 8'h57, 8'h92, 8'hb4: is_unsup = 1'b1;
			default: is_unsup = 1'b0;
		endcase
	endfunction

	function automatic logic is_media(input logic [7:0] op);
		case (op)
			8'h20, 8'h24, 8'h25, 8'h29, 8'h30, 8'h34, 8'h35, 8'h39, 8'h40, 8'h42,
			8'h60, 8'h61, 8'hc4, 8'hc5, 8'hc8, 8'hca, 8'hce: is_media = 1'b1;
			default: is_media = 1'b0;
		endcase
	endfunction

	function automatic logic is_known(input logic [7:0] op);
		case (op)
			8'h00, 8'h06, 8'h27, 8'h2f, 8'h37, 8'h3f, 8'h90, 8'hb0, 8'hb1, 8'hc6,
			8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5, 8'he6, 8'he7, 8'he8, 8'he9,
			8'hea, 8'heb, 8'hec, 8'hef, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6,
			8'hf8, 8'hf9: is_known = 1'b1;
			default: is_known = is_media(op);
		endcase
	endfunction

	function automatic logic [15:0] job_len(input asc_job_e j);
		case (j)
			J_ATTR, J_SAVE: job_len = asc_pkg::SAVE_CYCLES;
			J_THR: job_len = asc_pkg::FETCH_CYCLES;
			J_TEST: job_len = asc_pkg::TEST_CYCLES;
			J_ERASE: job_len = asc_pkg::ERASE_CYCLES;
			default: job_len = 16'h0001;
		endcase
	endfunction

	asc_state_e st_q;
	asc_job_e job_q, job_c;
	logic [15:0] cnt_q, off_cnt_q;
	logic [7:0] idx_q, save_cnt_q;
	logic locked_q, user_set_q, lvl_max_q, autosave_q, first_idle_q;
	logic [15:0] user_pw_q, master_pw_q;
	logic off_pause_q, off_keep_q;
	logic [31:0] div_q, ms_q;
	logic take, busy_end, done, abort_c, strobe_c, as_set_c, off_start_c, off_stop_c;
	logic pw_set_c, unlock_c, pwdis_c, save_now;
	logic [15:0] pw;

	assign take = LINK.cmd_wr && st_q == S_IDLE;
	assign pw = {LINK.lba_high, LINK.lba_low};
	assign busy_end = st_q == S_BUSY && cnt_q == 16'h0000;
	assign done = (take && job_c == J_NONE) || (busy_end && job_q != J_ATTR && job_q != J_THR)
		|| (st_q == S_XFER && LINK.data_rd && idx_q == asc_pkg::XFER_LAST);

	// ========================================
	// decode of a taken command
	always_comb begin
		job_c = J_NONE;
		abort_c = 1'b0;
		strobe_c = 1'b0;
		as_set_c = 1'b0;
		off_start_c = 1'b0;
		off_stop_c = 1'b0;
		pw_set_c = 1'b0;
		unlock_c = 1'b0;
		pwdis_c = 1'b0;
		if (take) begin
			if (is_unsup(LINK.cmd) || !is_known(LINK.cmd)) begin
				abort_c = 1'b1;
			end else if (locked_q && is_media(LINK.cmd)) begin
				abort_c = 1'b1;
			end else begin
				case (LINK.cmd)
					asc_pkg::OP_SMART: begin
						case (LINK.feature)
							asc_pkg::SM_READ_DATA: job_c = J_ATTR;
							asc_pkg::SM_READ_THR: job_c = J_THR;
							asc_pkg::SM_AUTOSAVE: begin
								if (LINK.sect_cnt == asc_pkg::AS_OFF || LINK.sect_cnt == asc_pkg::AS_ON) begin
									as_set_c = 1'b1;
									job_c = J_BRIEF;
								end else begin
									abort_c = 1'b1;
								end
							end
							asc_pkg::SM_SAVE: job_c = J_SAVE;
							asc_pkg::SM_EXEC: begin
								case (LINK.lba_low)
									asc_pkg::EX_COLLECT, asc_pkg::EX_SHORT, asc_pkg::EX_EXTEND,
									asc_pkg::EX_SELECT: off_start_c = 1'b1;
									asc_pkg::EX_ABORT: off_stop_c = 1'b1;
									asc_pkg::EX_CAP_SHORT, asc_pkg::EX_CAP_EXTEND,
									asc_pkg::EX_CAP_SELECT: job_c = J_TEST;
									default: abort_c = 1'b1;
								endcase
							end
							default: begin
								abort_c = LINK.feature < asc_pkg::SM_READ_DATA || LINK.feature > asc_pkg::SM_LAST
									|| LINK.feature == asc_pkg::SM_HOLE;
							end
						endcase
					end
					asc_pkg::OP_SET_PW: pw_set_c = 1'b1;
					asc_pkg::OP_UNLOCK: begin
						if (pw == user_pw_q || (pw == master_pw_q && !lvl_max_q))
							unlock_c = 1'b1;
						else if (locked_q)
							abort_c = 1'b1;
					end
					asc_pkg::OP_ERASE_UNIT: begin
						if (pw == user_pw_q || pw == master_pw_q)
							job_c = J_ERASE;
						else
							abort_c = 1'b1;
					end
					asc_pkg::OP_DIS_PW: begin
						if (pw == user_pw_q && !locked_q)
							pwdis_c = 1'b1;
						else
							abort_c = 1'b1;
					end
					default: strobe_c = 1'b1;
				endcase
			end
		end
	end

	// ========================================
	// command flow and task-file outputs
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_q <= S_IDLE;
			job_q <= J_NONE;
			cnt_q <= 16'h0000;
			idx_q <= 8'h00;
			LINK.bsy <= 1'b0;
			LINK.drdy <= 1'b1;
			LINK.drq <= 1'b0;
			LINK.err <= 1'b0;
			LINK.intrq <= 1'b0;
			LINK.error <= 8'h00;
			LINK.lba_low_out <= 8'h00;
			LINK.lba_high_out <= 8'h00;
			LINK.data <= 16'h0000;
			LINK.data_valid <= 1'b0;
			CMD_STROBE <= 1'b0;
			CMD_CODE <= 8'h00;
		end else begin
			LINK.data_valid <= 1'b0;
			CMD_STROBE <= strobe_c;
			if (take) begin
				CMD_CODE <= LINK.cmd;
				LINK.lba_low_out <= 8'h00;
				LINK.lba_high_out <= 8'h00;
				LINK.err <= abort_c;
				LINK.error <= abort_c ? asc_pkg::ERR_ABRT : 8'h00;
				job_q <= job_c;
				if (job_c != J_NONE) begin
					st_q <= S_BUSY;
					cnt_q <= job_len(job_c) - 16'h0001;
					LINK.bsy <= 1'b1;
					LINK.intrq <= 1'b0;
				end else begin
					LINK.intrq <= 1'b1;
				end
			end
			case (st_q)
				S_BUSY: begin
					cnt_q <= cnt_q - 16'h0001;
					if (busy_end) begin
						LINK.bsy <= 1'b0;
						LINK.intrq <= 1'b1;
						if (job_q == J_ATTR || job_q == J_THR) begin
							st_q <= S_XFER;
							LINK.drq <= 1'b1;
							idx_q <= 8'h00;
						end else begin
							st_q <= S_IDLE;
						end
						if (job_q == J_TEST && TEST_FAIL) begin
							LINK.err <= 1'b1;
							LINK.error <= asc_pkg::ERR_ABRT;
							LINK.lba_low_out <= asc_pkg::FAIL_LBA_LOW;
							LINK.lba_high_out <= asc_pkg::FAIL_LBA_HIGH;
						end
					end
				end
				S_XFER: begin
					if (LINK.data_rd) begin
						LINK.data <= {idx_q, job_q == J_ATTR ? save_cnt_q : (idx_q ^ asc_pkg::THR_PATTERN)};
						LINK.data_valid <= 1'b1;
						idx_q <= idx_q + 8'h01;
						if (idx_q == asc_pkg::XFER_LAST) begin
							LINK.drq <= 1'b0;
							st_q <= S_IDLE;
						end
					end
				end
				default: ;
			endcase
		end
	end

	// ========================================
	// security state; passwords and level survive power cycles
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			master_pw_q <= asc_pkg::MASTER_PW_RST;
			user_pw_q <= asc_pkg::MASTER_PW_RST;
			user_set_q <= 1'b0;
			lvl_max_q <= 1'b0;
			locked_q <= 1'b0;
		end else begin
			if (POWER_UP)
				locked_q <= user_set_q;
			else if (unlock_c || (busy_end && job_q == J_ERASE))
				locked_q <= 1'b0;
			if (pw_set_c && LINK.feature[0]) begin
				master_pw_q <= pw;
			end else if (pw_set_c) begin
				user_pw_q <= pw;
				user_set_q <= 1'b1;
				lvl_max_q <= LINK.sect_cnt[0];
			end else if (pwdis_c) begin
				user_set_q <= 1'b0;
			end
		end
	end

	// ========================================
	// attribute saving; the timer runs off a 1 ms tick to keep counters narrow
	assign save_now = POWER_UP || POWER_DOWN || (busy_end && (job_q == J_ATTR || job_q == J_SAVE))
		|| (autosave_q && ((IDLE_ENTER && first_idle_q) || ms_q == 32'(AUTOSAVE_TICKS - 1)));
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			autosave_q <= 1'b0;
			first_idle_q <= 1'b1;
			div_q <= 32'h0000_0000;
			ms_q <= 32'h0000_0000;
			save_cnt_q <= 8'h00;
			ATTR_SAVE <= 1'b0;
		end else begin
			ATTR_SAVE <= save_now;
			if (as_set_c)
				autosave_q <= LINK.sect_cnt == asc_pkg::AS_ON;
			if (POWER_UP)
				first_idle_q <= 1'b1;
			else if (IDLE_ENTER)
				first_idle_q <= 1'b0;
			div_q <= (div_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_q + 32'h0000_0001;
			if (save_now) begin
				save_cnt_q <= save_cnt_q + 8'h01;
				ms_q <= 32'h0000_0000;
			end else if (div_q == 32'(TICK_CYCLES - 1)) begin
				ms_q <= ms_q + 32'h0000_0001;
			end
		end
	end

	// ========================================
	// offline routine and self-test status byte
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			OFFLINE_RUN <= 1'b0;
			off_cnt_q <= 16'h0000;
			off_pause_q <= 1'b0;
			off_keep_q <= 1'b0;
			SELFTEST_STATUS <= asc_pkg::STS_PASS;
		end else begin
			if (OFFLINE_RUN && !off_pause_q && st_q == S_IDLE && !take) begin
				off_cnt_q <= off_cnt_q + 16'h0001;
				if (off_cnt_q == asc_pkg::OFFLINE_CYCLES - 16'h0001) begin
					OFFLINE_RUN <= 1'b0;
					SELFTEST_STATUS <= TEST_FAIL ? asc_pkg::STS_FAILED : asc_pkg::STS_PASS;
				end
			end
			if (OFFLINE_RUN && take) begin
				off_pause_q <= 1'b1;
				off_keep_q <= LINK.cmd != asc_pkg::OP_STANDBY_IMM && LINK.cmd != asc_pkg::OP_STANDBY
					&& LINK.cmd != asc_pkg::OP_SLEEP && LINK.cmd != asc_pkg::OP_ERASE_UNIT;
			end
			if (done && (off_pause_q || (OFFLINE_RUN && take))) begin
				off_pause_q <= 1'b0;
				if (!(off_pause_q ? off_keep_q : (LINK.cmd != asc_pkg::OP_STANDBY_IMM
					&& LINK.cmd != asc_pkg::OP_STANDBY && LINK.cmd != asc_pkg::OP_SLEEP))) begin
					OFFLINE_RUN <= 1'b0;
					SELFTEST_STATUS <= asc_pkg::STS_ABORTED;
				end
			end
			if (busy_end && job_q == J_TEST)
				SELFTEST_STATUS <= TEST_FAIL ? asc_pkg::STS_FAILED : asc_pkg::STS_PASS;
			if (off_start_c) begin
				OFFLINE_RUN <= 1'b1;
				off_cnt_q <= 16'h0000;
				off_pause_q <= 1'b0;
				SELFTEST_STATUS <= asc_pkg::STS_RUNNING;
			end else if (off_stop_c || (busy_end && job_q == J_ERASE)) begin
				OFFLINE_RUN <= 1'b0;
				off_pause_q <= 1'b0;
				SELFTEST_STATUS <= asc_pkg::STS_ABORTED;
			end
		end
	end

	assign LOCKED = locked_q;
	assign AUTOSAVE_ON = autosave_q;
endmodule
`default_nettype wire

// ===== verilog/asc_host.sv
// Purpose: host end issuing one command at a time and collecting its answer
// Assumes: device answers each data_rd with data_valid one cycle later
// Notes: REQ is taken only while READY is high
`timescale 1ns/1ps
`default_nettype none
module asc_host (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	asc_if.host LINK,
	input wire logic REQ,
	input wire logic [7:0] REQ_CMD,
	input wire logic [7:0] REQ_FEAT,
	input wire logic [7:0] REQ_CNT,
	input wire logic [7:0] REQ_LBA_LOW,
	input wire logic [7:0] REQ_LBA_HIGH,
	output logic READY,
	output logic DONE,
	output logic DONE_ERR,
	output logic [7:0] DONE_ERROR,
	output logic [7:0] DONE_LBA_LOW,
	output logic [7:0] DONE_LBA_HIGH,
	output logic [15:0] RD_DATA,
	output logic RD_VALID
);
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_ISSUE = 2'b01, H_WAIT = 2'b11, H_READ = 2'b10} asc_hstate_e;
	asc_hstate_e st_q;
	logic pend_q;
	logic [7:0] cnt_q;

	// ========================================
	// issue and collect; ISSUE state lets the device clear intrq before we look
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_q <= H_IDLE;
			pend_q <= 1'b0;
			cnt_q <= 8'h00;
			LINK.cmd_wr <= 1'b0;
			LINK.cmd <= 8'h00;
			LINK.feature <= 8'h00;
			LINK.sect_cnt <= 8'h00;
			LINK.lba_low <= 8'h00;
			LINK.lba_high <= 8'h00;
			LINK.data_rd <= 1'b0;
			READY <= 1'b0;
			DONE <= 1'b0;
			DONE_ERR <= 1'b0;
			DONE_ERROR <= 8'h00;
			DONE_LBA_LOW <= 8'h00;
			DONE_LBA_HIGH <= 8'h00;
			RD_DATA <= 16'h0000;
			RD_VALID <= 1'b0;
		end else begin
			LINK.cmd_wr <= 1'b0;
			LINK.data_rd <= 1'b0;
			DONE <= 1'b0;
			RD_VALID <= 1'b0;
			READY <= st_q == H_IDLE && !LINK.bsy && !LINK.drq && !(REQ && READY);
			case (st_q)
				H_IDLE: begin
					if (REQ && READY) begin
						LINK.cmd_wr <= 1'b1;
						LINK.cmd <= REQ_CMD;
						LINK.feature <= REQ_FEAT;
						LINK.sect_cnt <= REQ_CNT;
						LINK.lba_low <= REQ_LBA_LOW;
						LINK.lba_high <= REQ_LBA_HIGH;
						st_q <= H_ISSUE;
					end
				end
				H_ISSUE: st_q <= H_WAIT;
				H_WAIT: begin
					if (LINK.intrq && LINK.drq) begin
						st_q <= H_READ;
						cnt_q <= 8'h00;
						pend_q <= 1'b0;
					end else if (LINK.intrq) begin
						st_q <= H_IDLE;
						DONE <= 1'b1;
						DONE_ERR <= LINK.err;
						DONE_ERROR <= LINK.error;
						DONE_LBA_LOW <= LINK.lba_low_out;
						DONE_LBA_HIGH <= LINK.lba_high_out;
					end
				end
				H_READ: begin
					if (!pend_q) begin
						LINK.data_rd <= 1'b1;
						pend_q <= 1'b1;
					end
					if (LINK.data_valid) begin
						pend_q <= 1'b0;
						RD_DATA <= LINK.data;
						RD_VALID <= 1'b1;
						cnt_q <= cnt_q + 8'h01;
						if (cnt_q == asc_pkg::XFER_LAST) begin
							st_q <= H_IDLE;
							DONE <= 1'b1;
							DONE_ERR <= LINK.err;
							DONE_ERROR <= LINK.error;
							DONE_LBA_LOW <= LINK.lba_low_out;
							DONE_LBA_HIGH <= LINK.lba_high_out;
						end
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire
